/* vpic_pkg.sv */
// Function
// - Eight-bit data path, driven only when enabled
// - Writes load four init and three operation words
// - Cascade lines outputs on master, inputs on slave
// - Master puts granted slave id on cascade lines
// - Matching slave drives vector on next acknowledges
// - Acknowledges release vector bytes in processor format
// - Request output high while an unmasked request outranks every level in service
// - One pending bit per request line
// - One in-service bit per request line
// - Acknowledge sets in-service bit of winning request
// - Mask bit removes line from resolution and request
// - Masking high lines never blocks lower lines
// - Lines selectable edge or active-high level sensing
// - Eight lines per device, sixty-four when cascaded
// - Pending, in-service readable; mask writable and readable
// - Separate in/out ports, each output group enabled
package vpic_pkg;
  // Widths
  localparam int DW = 8;
  localparam int LVL_W = 3;
  // First init word fields
  localparam int W1_IC4 = 0;
  localparam int W1_SNGL = 1;
  localparam int W1_LTIM = 3;
  localparam int W1_MARK = 4;
  localparam int W1_ADDR_LO = 5;
  // Vector base field of second init word
  localparam int W2_BASE_LO = 3;
  // Processor mode bit of fourth init word
  localparam int W4_X86 = 0;
  // Operation word fields
  localparam int OP_IS_W3 = 3;
  localparam int OP_EOI = 5;
  localparam int OP_SPEC = 6;
  localparam int OP_RD_REG = 1;
  localparam int OP_RD_SEL = 0;
  // Acknowledge sequence constants
  localparam logic [1:0] PULSES_X86 = 2'h2;
  localparam logic [1:0] PULSES_X80 = 2'h3;
  localparam logic [1:0] PULSE_1 = 2'h1;
  localparam logic [1:0] PULSE_2 = 2'h2;
  localparam logic [1:0] PULSE_3 = 2'h3;
  localparam logic [7:0] CALL_OPCODE = 8'hCD;
  localparam logic [2:0] LVL_SPURIOUS = 3'h7;

  // Initialisation phases
  typedef enum logic [2:0] {
    PH_IDLE, PH_W2, PH_W3, PH_W4, PH_READY
  } vpic_phase_t;

  // Pins seen from outside the clock domain
  typedef struct packed {
    logic sel;
    logic rd_n;
    logic wr_n;
    logic cs_n;
    logic ack_n;
    logic sp_en;
    logic [LVL_W-1:0] cas;
    logic [DW-1:0] din;
    logic [DW-1:0] req;
  } vpic_pins_t;

  // Idle pin levels used as synchroniser reset
  localparam vpic_pins_t PINS_IDLE = '{rd_n: 1'h1, wr_n: 1'h1,
    cs_n: 1'h1, ack_n: 1'h1, default: '0};

  // Whole controller state
  typedef struct packed {
    vpic_phase_t phase;
    logic [DW-1:0] w1;
    logic [DW-1:0] w2;
    logic [DW-1:0] w3;
    logic [DW-1:0] w4;
    logic [DW-1:0] mask;
    logic [DW-1:0] pend;
    logic [DW-1:0] insvc;
    logic rd_isvc;
    logic [DW-1:0] req_prev;
    logic wr_prev;
    logic ack_prev;
    logic [1:0] pulse;
    logic [LVL_W-1:0] lvl;
    logic granted;
    logic mine;
    logic [DW-1:0] dout;
    logic doe;
    logic [LVL_W-1:0] cas;
    logic cas_oe;
    logic intr;
  } vpic_state_t;

  // Reset value of the state
  localparam vpic_state_t STATE_RST = '{phase: PH_IDLE, wr_prev: 1'h1,
    ack_prev: 1'h1, default: '0};

  // Lowest set bit: {found, index}
  function automatic logic [LVL_W:0] lowest_set(input logic [DW-1:0] v);
    logic [LVL_W:0] r;
    r = '0;
    for (int i = DW - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'h1, LVL_W'(i)};
      end
    end
    return r;
  endfunction : lowest_set
endpackage : vpic_pkg

/* vpic_sync.sv */
// Two-stage synchroniser for a bundle of pins
module vpic_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw and synchronised bundle
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // Stage 0 feeds only stage 1
  logic [1:0][W-1:0] s_reg;
  logic [1:0][W-1:0] s_next;

  // Shift one stage per clock
  always_comb begin
    s_next[0] = d;
    s_next[1] = s_reg[0];
  end

  // Registers, idle levels at reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= {INIT, INIT};
    end else begin
      s_reg <= s_next;
    end
  end

  // Output from second stage only
  assign q = s_reg[1];
endmodule : vpic_sync

/* vpic_prio.sv */
// Fully nested priority resolver, line 0 highest
module vpic_prio (
  // Register contents
  input wire logic [vpic_pkg::DW-1:0] pend,
  input wire logic [vpic_pkg::DW-1:0] mask,
  input wire logic [vpic_pkg::DW-1:0] insvc,
  // Winning line
  output logic valid,
  output logic [vpic_pkg::LVL_W-1:0] lvl
);
  // Found flag and index of best request and best in-service
  logic [vpic_pkg::LVL_W:0] top_req;
  logic [vpic_pkg::LVL_W:0] top_svc;

  // Masked lines drop out; unmasked lower ones still compete
  assign top_req = vpic_pkg::lowest_set(pend & ~mask);
  assign top_svc = vpic_pkg::lowest_set(insvc);

  // Win only above every level in service
  always_comb begin
    valid = top_req[vpic_pkg::LVL_W] && (!top_svc[vpic_pkg::LVL_W] ||
      top_req[vpic_pkg::LVL_W-1:0] < top_svc[vpic_pkg::LVL_W-1:0]);
    lvl = top_req[vpic_pkg::LVL_W-1:0];
  end
endmodule : vpic_prio

/* vpic_top.sv */
// Eight-line vectored priority interrupt controller
//
// The plain strobed port and the register offsets were chosen for this implementation.
module vpic_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Processor register port
  input wire logic REGISTER_SELECT_BIT,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic CS_N,
  input wire logic [vpic_pkg::DW-1:0] DIN,
  output logic [vpic_pkg::DW-1:0] DOUT,
  output logic DOUT_OE,
  // Request and acknowledge
  input wire logic [vpic_pkg::DW-1:0] REQUEST_LINES,
  input wire logic ACK_N,
  output logic INT_REQ,
  // Cascade id lines
  input wire logic [vpic_pkg::LVL_W-1:0] CASCADE_ID_LINES_IN,
  output logic [vpic_pkg::LVL_W-1:0] CASCADE_ID_LINES_OUT,
  output logic CASCADE_ID_LINES_OE,
  // Slave program / buffer enable
  input wire logic SP_EN_IN,
  output logic SP_EN_OUT,
  output logic SP_EN_OE
);
  // Raw and synchronised pins
  vpic_pkg::vpic_pins_t pins_raw;
  vpic_pkg::vpic_pins_t pins;
  // State and its next value
  vpic_pkg::vpic_state_t s_reg;
  vpic_pkg::vpic_state_t s_next;
  // Resolver result
  logic grant_ok;
  logic [vpic_pkg::LVL_W-1:0] grant_lvl;
  // Decoded conditions
  logic ready;
  logic cascaded;
  logic master;
  logic x86;
  logic wr_go;
  logic rd_on;
  logic ack_fall;
  logic ack_rise;
  logic first;
  logic is_w1;
  logic own_call;
  logic slave_hit;
  logic [1:0] last_pulse;
  logic [1:0] cur_pulse;
  logic [vpic_pkg::LVL_W:0] eoi_top;

  // Gather pins into one bundle
  assign pins_raw = '{sel: REGISTER_SELECT_BIT, rd_n: RD_N, wr_n: WR_N,
    cs_n: CS_N, ack_n: ACK_N, sp_en: SP_EN_IN, cas: CASCADE_ID_LINES_IN,
    din: DIN, req: REQUEST_LINES};

  // Every pin crosses two flops before use
  vpic_sync #(
    .W($bits(vpic_pkg::vpic_pins_t)),
    .INIT(vpic_pkg::PINS_IDLE)
  ) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .d(pins_raw),
    .q(pins)
  );

  // Priority resolver
  vpic_prio u_prio (
    .pend(s_reg.pend),
    .mask(s_reg.mask),
    .insvc(s_reg.insvc),
    .valid(grant_ok),
    .lvl(grant_lvl)
  );

  // Mode and strobe decode
  always_comb begin
    ready = s_reg.phase == vpic_pkg::PH_READY;
    cascaded = !s_reg.w1[vpic_pkg::W1_SNGL];
    master = pins.sp_en;
    x86 = s_reg.w4[vpic_pkg::W4_X86];
    // Select low with exactly one strobe
    wr_go = !pins.cs_n && !pins.wr_n && pins.rd_n && s_reg.wr_prev;
    rd_on = !pins.cs_n && !pins.rd_n && pins.wr_n;
    // Acknowledge pulse edges
    ack_fall = !pins.ack_n && s_reg.ack_prev;
    ack_rise = pins.ack_n && !s_reg.ack_prev;
    first = s_reg.pulse == '0;
    is_w1 = !pins.sel && pins.din[vpic_pkg::W1_MARK];
    // Master or single device sends the call opcode
    own_call = master || !cascaded;
    // Slave sees its own id on the cascade lines
    slave_hit = pins.cas == s_reg.w3[vpic_pkg::LVL_W-1:0];
    last_pulse = x86 ? vpic_pkg::PULSES_X86 : vpic_pkg::PULSES_X80;
    cur_pulse = 2'(s_reg.pulse + 2'h1);
    eoi_top = vpic_pkg::lowest_set(s_reg.insvc);
  end

  // Next state
  always_comb begin
    logic [vpic_pkg::DW-1:0] clr;
    logic [vpic_pkg::DW-1:0] rise;
    clr = '0;
    rise = pins.req & ~s_reg.req_prev;
    s_next = s_reg;
    s_next.wr_prev = pins.wr_n;
    s_next.ack_prev = pins.ack_n;
    s_next.req_prev = pins.req;

    // Command words from processor writes
    if (wr_go) begin
      if (is_w1) begin
        // Restart of initialisation clears mode word 4, mask, in-service and acknowledge state
        s_next.w1 = pins.din;
        s_next.w4 = '0;
        s_next.phase = vpic_pkg::PH_W2;
        s_next.mask = '0;
        s_next.insvc = '0;
        s_next.rd_isvc = 1'h0;
        s_next.pulse = '0;
        s_next.cas_oe = 1'h0;
        s_next.mine = 1'h0;
      end else begin
        case (s_reg.phase)
          vpic_pkg::PH_W2: begin
            // Vector base; skip cascade word when single
            s_next.w2 = pins.din;
            if (cascaded) begin
              s_next.phase = vpic_pkg::PH_W3;
            end else if (s_reg.w1[vpic_pkg::W1_IC4]) begin
              s_next.phase = vpic_pkg::PH_W4;
            end else begin
              s_next.phase = vpic_pkg::PH_READY;
            end
          end
          vpic_pkg::PH_W3: begin
            // Slave map on master, own id on slave
            s_next.w3 = pins.din;
            if (s_reg.w1[vpic_pkg::W1_IC4]) begin
              s_next.phase = vpic_pkg::PH_W4;
            end else begin
              s_next.phase = vpic_pkg::PH_READY;
            end
          end
          vpic_pkg::PH_W4: begin
            // Processor mode
            s_next.w4 = pins.din;
            s_next.phase = vpic_pkg::PH_READY;
          end
          vpic_pkg::PH_READY: begin
            if (pins.sel) begin
              // Mask word
              s_next.mask = pins.din;
            end else if (pins.din[vpic_pkg::OP_IS_W3]) begin
              // Read select word
              if (pins.din[vpic_pkg::OP_RD_REG]) begin
                s_next.rd_isvc = pins.din[vpic_pkg::OP_RD_SEL];
              end
            end else if (pins.din[vpic_pkg::OP_EOI]) begin
              // End of interrupt: one to clear a level in service
              if (pins.din[vpic_pkg::OP_SPEC]) begin
                s_next.insvc[pins.din[vpic_pkg::LVL_W-1:0]] = 1'h0;
              end else if (eoi_top[vpic_pkg::LVL_W]) begin
                s_next.insvc[eoi_top[vpic_pkg::LVL_W-1:0]] = 1'h0;
              end
            end
          end
          default: begin
            // Not initialised: writes ignored
          end
        endcase
      end
    end

    // First acknowledge falls: freeze winner
    if (ready && ack_fall && first) begin
      s_next.lvl = grant_ok ? grant_lvl : vpic_pkg::LVL_SPURIOUS;
      s_next.granted = grant_ok;
      s_next.mine = own_call && !(cascaded && s_reg.w3[grant_lvl]);
      if (grant_ok && own_call) begin
        s_next.insvc[grant_lvl] = 1'h1;
        clr[grant_lvl] = 1'h1;
      end
      // Master names the slave behind the granted line
      if (grant_ok && master && cascaded && s_reg.w3[grant_lvl]) begin
        s_next.cas = grant_lvl;
        s_next.cas_oe = 1'h1;
      end
    end

    // Slave checks the id at the end of the first pulse
    if (ready && ack_rise && first && cascaded && !master) begin
      if (slave_hit) begin
        s_next.mine = 1'h1;
        if (s_reg.granted) begin
          s_next.insvc[s_reg.lvl] = 1'h1;
          clr[s_reg.lvl] = 1'h1;
        end
      end
    end

    // Count pulses; sequence ends after the last one
    if (ready && ack_rise) begin
      if (cur_pulse == last_pulse) begin
        s_next.pulse = '0;
        s_next.cas_oe = 1'h0;
        s_next.mine = 1'h0;
      end else begin
        s_next.pulse = cur_pulse;
      end
    end

    // Pending bits; a new edge wins over the acknowledge clear
    if (!ready) begin
      s_next.pend = '0;
    end else if (s_reg.w1[vpic_pkg::W1_LTIM]) begin
      s_next.pend = pins.req;
    end else begin
      s_next.pend = (s_reg.pend & pins.req & ~clr) | rise;
    end

    // Data bus output
    s_next.doe = 1'h0;
    if (rd_on) begin
      // Status read: mask, or pending / in-service
      s_next.doe = 1'h1;
      if (pins.sel) begin
        s_next.dout = s_reg.mask;
      end else if (s_reg.rd_isvc) begin
        s_next.dout = s_reg.insvc;
      end else begin
        s_next.dout = s_reg.pend;
      end
    end else if (ready && !pins.ack_n && !first) begin
      // Vector bytes in later pulses
      if (x86) begin
        if (s_reg.mine && cur_pulse == vpic_pkg::PULSE_2) begin
          s_next.doe = 1'h1;
          s_next.dout = {s_reg.w2[vpic_pkg::DW-1:vpic_pkg::W2_BASE_LO],
            s_reg.lvl};
        end
      end else if (s_reg.mine && cur_pulse == vpic_pkg::PULSE_2) begin
        s_next.doe = 1'h1;
        s_next.dout = {s_reg.w1[vpic_pkg::DW-1:vpic_pkg::W1_ADDR_LO],
          s_reg.lvl, 2'h0};
      end else if (s_reg.mine && cur_pulse == vpic_pkg::PULSE_3) begin
        s_next.doe = 1'h1;
        s_next.dout = s_reg.w2;
      end
    end else if (ready && !pins.ack_n && !x86 && own_call) begin
      // Call opcode in the first pulse
      if (cur_pulse == vpic_pkg::PULSE_1) begin
        s_next.doe = 1'h1;
        s_next.dout = vpic_pkg::CALL_OPCODE;
      end
    end

    // Processor request
    s_next.intr = ready && grant_ok;
  end

  // State register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_reg <= vpic_pkg::STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs from flops
  assign DOUT = s_reg.dout;
  assign DOUT_OE = s_reg.doe;
  assign INT_REQ = s_reg.intr;
  assign CASCADE_ID_LINES_OUT = s_reg.cas;
  assign CASCADE_ID_LINES_OE = s_reg.cas_oe;
  // Buffered mode absent: pin is only an input
  assign SP_EN_OUT = 1'h0;
  assign SP_EN_OE = 1'h0;

  // Read of the mask shows it next cycle
  a_read_mask: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_on && pins.sel |=> DOUT_OE && DOUT == $past(s_reg.mask))
    else $error("mask read not returned");

  // First init word restarts the sequence
  a_init_restart: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_go && is_w1 |=> s_reg.phase == vpic_pkg::PH_W2 && s_reg.mask == '0)
    else $error("init word did not restart");

  // Cascade drivers only on a cascaded master
  a_cas_master: assert property (@(posedge CLK) disable iff (!RST_N)
    CASCADE_ID_LINES_OE |-> master && cascaded)
    else $error("cascade driven while not master");

  // Granted slave line named on cascade
  a_cas_id_out: assert property (@(posedge CLK) disable iff (!RST_N)
    ready && ack_fall && first && grant_ok && master && cascaded &&
    s_reg.w3[grant_lvl] |=> CASCADE_ID_LINES_OE &&
    CASCADE_ID_LINES_OUT == $past(grant_lvl))
    else $error("slave id not placed");

  // Matching slave takes the vector bytes
  a_slave_match: assert property (@(posedge CLK) disable iff (!RST_N)
    ready && ack_rise && first && cascaded && !master && slave_hit
    |=> s_reg.mine)
    else $error("matching slave not selected");

  // Second pulse in x86 mode drives a byte whose low bits hold the level
  a_x86_vector: assert property (@(posedge CLK) disable iff (!RST_N)
    ready && x86 && s_reg.mine && !pins.ack_n && !rd_on &&
    cur_pulse == vpic_pkg::PULSE_2 |=> DOUT_OE &&
    DOUT[vpic_pkg::LVL_W-1:0] == $past(s_reg.lvl))
    else $error("vector byte missing");

  // Request output follows resolver, two cycles at most
  a_int_follow: assert property (@(posedge CLK) disable iff (!RST_N)
    ready && grant_ok ##1 ready && grant_ok |-> INT_REQ)
    else $error("request output not raised");

  // Acknowledge marks the winner in service
  a_isvc_set: assert property (@(posedge CLK) disable iff (!RST_N)
    ready && ack_fall && first && grant_ok && own_call
    |=> s_reg.insvc[$past(grant_lvl)])
    else $error("in-service bit not set");

  // A masked line never wins
  a_mask_block: assert property (@(posedge CLK) disable iff (!RST_N)
    grant_ok |-> !s_reg.mask[grant_lvl])
    else $error("masked line granted");

  // Lowest line still wins with all others masked
  a_low_unblock: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reg.pend[vpic_pkg::DW-1] && s_reg.mask == 8'h7F &&
    s_reg.insvc == '0 |-> grant_ok)
    else $error("lower line blocked by mask");

  // Rising edge is caught in edge mode
  a_edge_catch: assert property (@(posedge CLK) disable iff (!RST_N)
    ready && !s_reg.w1[vpic_pkg::W1_LTIM] && pins.req[0] &&
    !s_reg.req_prev[0] |=> s_reg.pend[0])
    else $error("edge request lost");

  // Line zero beats all others
  a_line0_top: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reg.pend[0] && !s_reg.mask[0] && s_reg.insvc == '0
    |-> grant_ok && grant_lvl == '0)
    else $error("line zero not highest");
endmodule : vpic_top

/* vpic_cpu.sv */
// Processor side model: register strobes and acknowledge pulses
module vpic_cpu (
  // Clock
  input wire logic clk,
  // Pins driven towards the controller
  output logic sel,
  output logic rd_n,
  output logic wr_n,
  output logic cs_n,
  output logic ack_n,
  output logic [vpic_pkg::DW-1:0] din,
  // Data seen from the controller
  input wire logic [vpic_pkg::DW-1:0] dout,
  input wire logic dout_oe
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle levels at time zero
  initial begin
    sel = 1'h0;
    rd_n = 1'h1;
    wr_n = 1'h1;
    cs_n = 1'h1;
    ack_n = 1'h1;
    din = 8'h00;
  end

  // Select with exactly one strobe, held past the sync delay
  task automatic access(input logic rd, input logic a,
    input logic [7:0] d, output logic [7:0] q, output logic oe);
    @(posedge clk);
    cs_n <= 1'h0;
    sel <= a;
    din <= d;
    if (rd) begin
      rd_n <= 1'h0;
    end else begin
      wr_n <= 1'h0;
    end
    repeat (5) @(posedge clk);
    @(negedge clk);
    oe = dout_oe;
    q = dout_oe ? dout : 8'hxx;
    @(posedge clk);
    cs_n <= 1'h1;
    rd_n <= 1'h1;
    wr_n <= 1'h1;
    // Released data shows the inverse, never the old value
    din <= ~d;
    repeat (5) @(posedge clk);
  endtask : access

  // One acknowledge pulse; the byte is taken while it is low
  task automatic ack(output logic [7:0] q, output logic oe);
    @(posedge clk);
    ack_n <= 1'h0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    oe = dout_oe;
    q = dout_oe ? dout : 8'hxx;
    @(posedge clk);
    ack_n <= 1'h1;
    repeat (6) @(posedge clk);
  endtask : ack
endmodule : vpic_cpu

/* vpic_top_tb.sv */
// Self-checking bench for the interrupt controller
module vpic_top_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // Design pins
  logic CLK = 1'h0;
  logic RST_N = 1'h0;
  logic REGISTER_SELECT_BIT, RD_N, WR_N, CS_N, ACK_N;
  logic [7:0] DIN, DOUT, REQUEST_LINES = 8'h00;
  logic DOUT_OE, INT_REQ, CASCADE_ID_LINES_OE, SP_EN_IN = 1'h0;
  logic SP_EN_OUT, SP_EN_OE;
  logic [2:0] CASCADE_ID_LINES_IN = 3'h0, CASCADE_ID_LINES_OUT;
  // Counters and last sampled byte
  int errors = 0;
  int tests_run = 0;
  logic [7:0] q;
  logic oe;

  // 50 MHz clock
  always #10 CLK = ~CLK;

  vpic_top vpic_top_i (.CLK(CLK), .RST_N(RST_N),
    .REGISTER_SELECT_BIT(REGISTER_SELECT_BIT), .RD_N(RD_N), .WR_N(WR_N),
    .CS_N(CS_N), .DIN(DIN), .DOUT(DOUT), .DOUT_OE(DOUT_OE),
    .REQUEST_LINES(REQUEST_LINES), .ACK_N(ACK_N), .INT_REQ(INT_REQ),
    .CASCADE_ID_LINES_IN(CASCADE_ID_LINES_IN),
    .CASCADE_ID_LINES_OUT(CASCADE_ID_LINES_OUT),
    .CASCADE_ID_LINES_OE(CASCADE_ID_LINES_OE), .SP_EN_IN(SP_EN_IN),
    .SP_EN_OUT(SP_EN_OUT), .SP_EN_OE(SP_EN_OE));

  vpic_cpu vpic_cpu_i (.clk(CLK), .sel(REGISTER_SELECT_BIT), .rd_n(RD_N),
    .wr_n(WR_N), .cs_n(CS_N), .ack_n(ACK_N), .din(DIN), .dout(DOUT),
    .dout_oe(DOUT_OE));

  // Byte compare
  task automatic check8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check8

  // Flag compare
  task automatic check1(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check1

  // Register write and checked read
  task automatic wr(input logic a, input logic [7:0] d);
    vpic_cpu_i.access(1'h0, a, d, q, oe);
  endtask : wr

  task automatic rdchk(input logic a, input logic [7:0] e);
    vpic_cpu_i.access(1'h1, a, 8'h00, q, oe);
    check8(q, e);
  endtask : rdchk

  // Init words in order, then mask cleared
  task automatic init(input logic [7:0] w1, w2, w3, w4);
    wr(1'h0, w1);
    wr(1'h1, w2);
    if (!w1[vpic_pkg::W1_SNGL]) begin
      wr(1'h1, w3);
    end
    if (w1[vpic_pkg::W1_IC4]) begin
      wr(1'h1, w4);
    end
    wr(1'h1, 8'h00);
  endtask : init

  // Let requests ripple through sync and resolver
  task automatic settle;
    repeat (10) @(posedge CLK);
    @(negedge CLK);
  endtask : settle

  // Edge mode, x86 vectors, masking and nesting
  task automatic t_prio;
    init(8'h13, 8'h40, 8'h00, 8'h01);
    wr(1'h1, 8'hA5);
    rdchk(1'h1, 8'hA5);
    wr(1'h1, 8'h01);
    rdchk(1'h1, 8'h01);
    REQUEST_LINES <= 8'h09;
    settle();
    check1(INT_REQ, 1'h1);
    wr(1'h0, 8'h0A);
    rdchk(1'h0, 8'h09);
    vpic_cpu_i.ack(q, oe);
    vpic_cpu_i.ack(q, oe);
    check8(q, 8'h43);
    settle();
    check1(INT_REQ, 1'h0);
    wr(1'h0, 8'h0B);
    rdchk(1'h0, 8'h08);
    wr(1'h1, 8'h00);
    settle();
    check1(INT_REQ, 1'h1);
    vpic_cpu_i.ack(q, oe);
    vpic_cpu_i.ack(q, oe);
    check8(q, 8'h40);
    wr(1'h0, 8'h0B);
    rdchk(1'h0, 8'h09);
    // Non-specific end clears line 0, specific end clears line 3
    wr(1'h0, 8'h20);
    rdchk(1'h0, 8'h08);
    wr(1'h0, 8'h63);
    rdchk(1'h0, 8'h00);
    $display("test prio done");
  endtask : t_prio

  // Level mode, three-byte vectors, all eight lines
  task automatic t_level;
    REQUEST_LINES <= 8'h00;
    init(8'hFA, 8'h12, 8'h00, 8'h00);
    REQUEST_LINES <= 8'h20;
    settle();
    check1(INT_REQ, 1'h1);
    @(posedge CLK);
    REQUEST_LINES <= 8'h00;
    settle();
    check1(INT_REQ, 1'h0);
    @(posedge CLK);
    REQUEST_LINES <= 8'hFF;
    settle();
    wr(1'h0, 8'h0A);
    rdchk(1'h0, 8'hFF);
    vpic_cpu_i.ack(q, oe);
    check8(q, 8'hCD);
    vpic_cpu_i.ack(q, oe);
    check8(q, 8'hE0);
    vpic_cpu_i.ack(q, oe);
    check8(q, 8'h12);
    $display("test level done");
  endtask : t_level

  // Master hands a slave line to the cascade id lines
  task automatic t_master;
    REQUEST_LINES <= 8'h00;
    SP_EN_IN <= 1'h1;
    init(8'h11, 8'h20, 8'h04, 8'h01);
    REQUEST_LINES <= 8'h04;
    settle();
    check1(INT_REQ, 1'h1);
    vpic_cpu_i.ack(q, oe);
    @(negedge CLK);
    check1(CASCADE_ID_LINES_OE, 1'h1);
    check8({5'h00, CASCADE_ID_LINES_OUT}, 8'h02);
    vpic_cpu_i.ack(q, oe);
    check1(oe, 1'h0);
    $display("test master done");
  endtask : t_master

  // Slave answers only for its own id
  task automatic t_slave(input logic [2:0] id, input logic hit);
    REQUEST_LINES <= 8'h00;
    SP_EN_IN <= 1'h0;
    CASCADE_ID_LINES_IN <= id;
    init(8'h11, 8'h68, 8'h03, 8'h01);
    REQUEST_LINES <= 8'h02;
    settle();
    vpic_cpu_i.ack(q, oe);
    vpic_cpu_i.ack(q, oe);
    check1(oe, hit);
    check8(oe ? q : 8'h00, hit ? 8'h69 : 8'h00);
    @(negedge CLK);
    check1(CASCADE_ID_LINES_OE, 1'h0);
    check1(SP_EN_OE, 1'h0);
    check1(SP_EN_OUT, 1'h0);
    // Only the matching slave marks the line in service
    wr(1'h0, 8'h0B);
    rdchk(1'h0, hit ? 8'h02 : 8'h00);
    $display("test slave done");
  endtask : t_slave

  // Counts, verdict, end of run
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    repeat (11) @(posedge CLK);
    @(negedge CLK);
    check1(DOUT_OE, 1'h0);
    @(posedge CLK);
    RST_N <= 1'h1;
    repeat (3) @(posedge CLK);
    REQUEST_LINES <= 8'hFF;
    settle();
    check1(INT_REQ, 1'h0);
    check1(CASCADE_ID_LINES_OE, 1'h0);
    @(posedge CLK);
    REQUEST_LINES <= 8'h00;
    t_prio();
    t_level();
    t_master();
    t_slave(3'h5, 1'h0);
    t_slave(3'h3, 1'h1);
    summarize();
  end

  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge CLK);
    errors++;
    summarize();
  end
endmodule : vpic_top_tb
